// ### design/imc_pkg.sv
// package for the interrupt mask control block
package imc_pkg;
  localparam logic [6:0] IMC_OFS_MASK = 7'h09;
  localparam logic [15:0] IMC_RST_MASK = 16'h0140;
  localparam logic [15:0] IMC_WR_MASK = 16'h01FF;
  localparam int IMC_BIT_SUPPLY = 0;
  localparam int IMC_BIT_TEMP = 1;
  localparam int IMC_BIT_BUS = 2;
  localparam int IMC_BIT_HS = 3;
  localparam int IMC_BIT_BD = 4;
  localparam int IMC_BIT_SPI = 5;
  localparam int IMC_BIT_WDF = 6;
  localparam int IMC_BIT_WDOFF = 7;
  localparam int IMC_BIT_REP = 8;
  localparam int IMC_CLK_MHZ = 40;
  localparam int IMC_PULSE_NS = 1000;
  localparam int IMC_PULSE_CYC = (IMC_PULSE_NS * IMC_CLK_MHZ) / 1000;
  localparam int IMC_REPEAT_US = 10000;
  localparam int IMC_REPEAT_CYC = IMC_REPEAT_US * IMC_CLK_MHZ;
  // one-cycle event strobes from the sources
  typedef struct packed {
    logic wdog_fail;
    logic spi_fail;
    logic bridge;
    logic high_side;
    logic bus;
    logic temp;
    logic supply;
  } imc_events_t;
endpackage

// ### design/imc_top.sv
// interrupt mask register and interrupt pulse generator
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - repeat pulses while interrupts pending, if enabled
// - bit 7 disables watchdog in development mode
// - bit 6: one pulse on watchdog failure, in development mode only
// - bit 5: pulse on frame or checksum failure
// - bit 4: pulse on bridge driver flag
// - bit 3: pulse on high side flag
// - bit 2: pulse on bus flag
// - bit 1: pulse on temperature flag
// - bit 0: pulse on supply flag
// - every enabled event that arrives while idle pulses, not only flag edges
// - bits 15:9 read zero, ignore writes
// - power-on reset value 0x0140
// - restart clears 15:9, keeps 8:0
module imc_top #(
  parameter int PULSE_CYC = imc_pkg::IMC_PULSE_CYC,
  parameter int REPEAT_CYC = imc_pkg::IMC_REPEAT_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_restart,
  // register access
  input wire logic i_reg_wr,
  input wire logic [6:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  // event sources
  input wire imc_pkg::imc_events_t i_events,
  input wire logic i_devmode,
  input wire logic i_irq_pending,
  // outputs
  output logic o_irq_request_pin_n,
  output logic o_devmode_wdog_off
);
  initial begin
    if (PULSE_CYC < 1 || REPEAT_CYC <= PULSE_CYC)
      $error("imc_top: bad pulse or repeat count");
  end

  typedef enum logic [1:0] {
    IMC_IDLE = 2'b01,
    IMC_PULSE = 2'b10
  } imc_state_t;

  logic [15:0] mask;
  logic [15:0] next_mask;
  imc_state_t state;
  imc_state_t next_state;
  logic [31:0] pulse_cnt;
  logic [31:0] next_pulse_cnt;
  logic [31:0] rep_cnt;
  logic [31:0] next_rep_cnt;
  logic ev_hit;
  logic rep_hit;

  // register write and reset handling
  always_comb begin
    next_mask = mask;
    if (i_reg_wr && i_reg_addr == imc_pkg::IMC_OFS_MASK) begin
      next_mask = i_reg_wdata & imc_pkg::IMC_WR_MASK;
    end
    if (i_restart) begin
      next_mask = mask & imc_pkg::IMC_WR_MASK;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      mask <= imc_pkg::IMC_RST_MASK;
    end else begin
      mask <= next_mask;
    end
  end

  assign o_reg_rdata = (i_reg_addr == imc_pkg::IMC_OFS_MASK) ? mask : 16'h0000;
  assign o_devmode_wdog_off = i_devmode && mask[imc_pkg::IMC_BIT_WDOFF];

  // events are strobes, so repeats of a set flag still count
  always_comb begin
    ev_hit = 1'b0;
    ev_hit = ev_hit | (i_events.supply & mask[imc_pkg::IMC_BIT_SUPPLY]);
    ev_hit = ev_hit | (i_events.temp & mask[imc_pkg::IMC_BIT_TEMP]);
    ev_hit = ev_hit | (i_events.bus & mask[imc_pkg::IMC_BIT_BUS]);
    ev_hit = ev_hit | (i_events.high_side & mask[imc_pkg::IMC_BIT_HS]);
    ev_hit = ev_hit | (i_events.bridge & mask[imc_pkg::IMC_BIT_BD]);
    ev_hit = ev_hit | (i_events.spi_fail & mask[imc_pkg::IMC_BIT_SPI]);
    ev_hit = ev_hit | (i_events.wdog_fail & i_devmode
                       & mask[imc_pkg::IMC_BIT_WDF]);
  end

  assign rep_hit = mask[imc_pkg::IMC_BIT_REP] && i_irq_pending
                   && rep_cnt == 32'(REPEAT_CYC - 1);

  always_comb begin
    next_state = state;
    next_pulse_cnt = pulse_cnt;
    next_rep_cnt = rep_cnt;
    if (mask[imc_pkg::IMC_BIT_REP] && i_irq_pending && !rep_hit) begin
      next_rep_cnt = rep_cnt + 32'h1;
    end else begin
      next_rep_cnt = 32'h0;
    end
    unique case (state)
      IMC_IDLE: begin
        if (ev_hit || rep_hit) begin
          next_state = IMC_PULSE;
          next_pulse_cnt = 32'h0;
        end
      end
      IMC_PULSE: begin
        if (pulse_cnt == 32'(PULSE_CYC - 1)) begin
          next_state = IMC_IDLE;
        end else begin
          next_pulse_cnt = pulse_cnt + 32'h1;
        end
      end
      default: next_state = IMC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      state <= IMC_IDLE;
      pulse_cnt <= 32'h0;
      rep_cnt <= 32'h0;
    end else begin
      state <= next_state;
      pulse_cnt <= next_pulse_cnt;
      rep_cnt <= next_rep_cnt;
    end
  end

  // pin low while pulsing; events during a pulse merge into it
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_irq_request_pin_n <= 1'b1;
    end else begin
      o_irq_request_pin_n <= (next_state != IMC_PULSE);
    end
  end

  a_reserved_zero: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) mask[15:9] == 7'h00)
    else $error("reserved mask bits set");

  a_supply_pulse: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    (state == IMC_IDLE && i_events.supply && mask[0]) |=> !o_irq_request_pin_n)
    else $error("supply event gave no pulse");

  a_bridge_pulse: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    (state == IMC_IDLE && i_events.bridge && mask[4]) |=> !o_irq_request_pin_n)
    else $error("bridge event gave no pulse");

  a_no_masked: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    (state == IMC_IDLE && !ev_hit && !rep_hit) |=> o_irq_request_pin_n)
    else $error("pulse without enabled cause");

  a_wdog_off: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    o_devmode_wdog_off == (i_devmode && mask[7]))
    else $error("watchdog disable wrong");

  a_restart_keep: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    (i_restart) |=> mask[8:0] == $past(mask[8:0]))
    else $error("restart lost mask bits");

  a_reset_value: assert property (@(posedge i_clk_sys)
    !i_resetn |=> mask == 16'h0140)
    else $error("bad reset value");

  a_pulse_width: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    $rose(state == IMC_PULSE) |-> (state == IMC_PULSE) [*2])
    else $error("pulse too short");

  a_no_repeat_off: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) !mask[8] |-> !rep_hit)
    else $error("repeat while disabled");

  a_wdog_fail: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    (state == IMC_IDLE && i_events.wdog_fail && i_devmode && mask[6])
    |=> !o_irq_request_pin_n)
    else $error("watchdog failure gave no pulse");

endmodule // imc_top
`default_nettype wire

// ### tb/imc_host.sv
// host model that reaches the mask register
`timescale 1ns/100ps
`default_nettype none
module imc_host (
  // clock
  input wire logic i_clk_sys,
  // register access
  input wire logic [15:0] i_reg_rdata,
  output logic o_reg_wr,
  output logic [6:0] o_reg_addr,
  output logic [15:0] o_reg_wdata
);
  initial begin
    o_reg_wr = 1'b0;
    o_reg_addr = 7'h00;
    o_reg_wdata = 16'h0000;
  end
  // one-cycle strobe, data spoiled after so stale values never match
  task automatic write(input logic [6:0] addr, input logic [15:0] data);
    @(posedge i_clk_sys) #2;
    o_reg_wr = 1'b1;
    o_reg_addr = addr;
    o_reg_wdata = data;
    @(posedge i_clk_sys) #2;
    o_reg_wr = 1'b0;
    o_reg_wdata = ~data;
  endtask
  task automatic read(input logic [6:0] addr, output logic [15:0] data);
    @(posedge i_clk_sys) #2;
    o_reg_addr = addr;
    #5;
    data = i_reg_rdata;
  endtask
endmodule // imc_host
`default_nettype wire

// ### tb/interrupt_mask_control_bench.sv
// self-checking bench for the interrupt mask block
`timescale 1ns/100ps
`default_nettype none
module interrupt_mask_control_bench;
  localparam int PULSE = 4;
  localparam int REPEAT = 100;
  logic i_clk_sys, i_resetn, i_restart, i_devmode, i_irq_pending;
  logic reg_wr, pin_n, wdog_off, prev;
  logic [6:0] reg_addr;
  logic [15:0] wdata, rdata, rd, d, exp_mask;
  imc_pkg::imc_events_t ev;
  int n_fail, check_count, cyc, n;
  imc_host host (.i_clk_sys(i_clk_sys), .i_reg_rdata(rdata),
    .o_reg_wr(reg_wr), .o_reg_addr(reg_addr), .o_reg_wdata(wdata));
  imc_top #(.PULSE_CYC(PULSE), .REPEAT_CYC(REPEAT)) dut (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_restart(i_restart),
    .i_reg_wr(reg_wr), .i_reg_addr(reg_addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_events(ev), .i_devmode(i_devmode),
    .i_irq_pending(i_irq_pending), .o_irq_request_pin_n(pin_n),
    .o_devmode_wdog_off(wdog_off));
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // hang guard, far above the roughly 750 cycles needed
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr_chk(input logic [15:0] v);
    host.write(7'h09, v);
    exp_mask = v & 16'h01FF;
    host.read(7'h09, rd);
    chk("mask", exp_mask, rd);
    chk("wdog_off", {15'h0000, i_devmode & exp_mask[7]}, {15'h0000, wdog_off});
  endtask
  // strobe one source, count low cycles of the pin afterwards
  task automatic ev_pulse(input int b, output int lows);
    lows = 0;
    @(posedge i_clk_sys) #2;
    ev = imc_pkg::imc_events_t'(7'h01 << b);
    @(posedge i_clk_sys) #2;
    ev = '0;
    repeat (PULSE + 3) begin
      if (pin_n === 1'b0) lows++;
      @(posedge i_clk_sys) #2;
    end
  endtask
  task automatic count_falls(output int falls);
    falls = 0;
    repeat (250) begin
      prev = pin_n;
      @(posedge i_clk_sys) #2;
      if (prev === 1'b1 && pin_n === 1'b0) falls++;
    end
  endtask
  initial begin
    i_resetn = 1'b0;
    i_restart = 1'b0;
    i_devmode = 1'b0;
    i_irq_pending = 1'b0;
    ev = '0;
    void'($urandom(32'hAC20));
    repeat (2) @(posedge i_clk_sys);
    #2 i_resetn = 1'b1;
    host.read(7'h09, rd);
    chk("reset", 16'h0140, rd);
    host.read(7'h0A, rd);
    chk("unmapped", 16'h0000, rd);
    for (int b = 0; b < 7; b++) begin
      i_devmode = 1'($urandom);
      wr_chk(16'($urandom) | (16'h0001 << b));
      // a repeated event pulses again though its flag stays set
      repeat (2) begin
        ev_pulse(b, n);
        chk("pulse_on", ((b != 6) || i_devmode) ? PULSE : 0, 16'(n));
      end
      wr_chk(16'($urandom) & ~(16'h0001 << b));
      ev_pulse(b, n);
      chk("pulse_off", 16'h0000, 16'(n));
    end
    i_irq_pending = 1'b1;
    wr_chk(16'h0100);
    count_falls(n);
    chk("repeat_on", 16'h0001, {15'h0000, n >= 250 / REPEAT});
    wr_chk(16'h0000);
    count_falls(n);
    chk("repeat_off", 16'h0000, 16'(n));
    i_irq_pending = 1'b0;
    d = 16'($urandom);
    wr_chk(d);
    @(posedge i_clk_sys) #2 i_restart = 1'b1;
    @(posedge i_clk_sys) #2 i_restart = 1'b0;
    host.read(7'h09, rd);
    chk("restart", d & 16'h01FF, rd);
    end_of_test();
  end
endmodule // interrupt_mask_control_bench
`default_nettype wire
